/* File: rtl/pps_pkg.sv */
package pps_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] PPS_PWR_MGMT_OFFSET = 12'h408;
  localparam logic [31:0] PPS_PWR_MGMT_RESET = 32'h00000000;
  localparam int PPS_SRC_SEL_BIT = 27;
  localparam int PPS_BL_OVR_BIT = 25;
  localparam int PPS_PWR_REQ_BIT = 24;
  localparam int PPS_UP_VDD_DATA_BIT = 23;
  localparam int PPS_UP_DATA_CON_BIT = 22;
  localparam int PPS_UP_CON_BL_BIT = 21;
  localparam int PPS_DN_BL_CON_BIT = 20;
  localparam int PPS_DN_CON_DATA_BIT = 19;
  localparam int PPS_DN_DATA_VDD_BIT = 18;
  // Writable bits: 27, 25..18
  localparam logic [31:0] PPS_WR_MASK = 32'h0BFC0000;
  localparam logic [1:0] PPS_RESP_OKAY = 2'h0;
  localparam logic [1:0] PPS_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int PPS_CLK_MHZ = 125;
  localparam int PPS_MS_CYCLES = PPS_CLK_MHZ * 1000;
  localparam int PPS_SHORT_MS = 32;
  localparam int PPS_LONG_MS = 128;
  localparam logic [7:0] PPS_SHORT_MS_W = 8'(PPS_SHORT_MS);
  localparam logic [7:0] PPS_LONG_MS_W = 8'(PPS_LONG_MS);

  // Sequencer steps: 0 off, 1 vdd, 2 data, 3 contrast, 4 backlight on
  localparam logic [2:0] PPS_STEP_OFF = 3'h0;
  localparam logic [2:0] PPS_STEP_ON = 3'h4;

  typedef enum logic [2:0]
  {
    PPS_AX_IDLE = 3'b001,
    PPS_AX_WRESP = 3'b010,
    PPS_AX_RRESP = 3'b100
  } pps_ax_t;
endpackage

/* File: rtl/pps_top.sv */
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
// Operation
// R1: Bit 27 of register 0x408 picks internal (0) or external (1) sequencing.
// R2: In external mode bits 24..18 have no effect on any output.
// R3: External mode: vdd enable follows vdd request, contrast follows lcd request.
// R4: External mode: backlight-off follows bit 25 written by software.
// R5: Internal mode: vdd, data, contrast and backlight sequenced automatically.
// R6: Internal mode: bit 24 written 0 to 1 starts power-up, delays bits 23..21.
// R7: Internal mode: bit 24 written 1 to 0 starts power-down, delays 20..18.
// R8: Bit 24 readable anytime; one means panel on, zero means off.
// R9: Each delay bit selects 32 ms when zero, 128 ms when one.
// R10: Bit 25 one forces backlight off at once; zero follows sequence.
// R11: Bit 24 starts sequences only while internal sequencing is selected.
// R12: Register resets to zero: internal mode, panel off, short delays.
// R13: Up: vdd, delay, data, delay, contrast, delay, backlight released.
// R14: Down: backlight off, delay, contrast off, delay, data off, delay, vdd off.
// R15: Backlight-off output is active low.
// R16: Delays next to backlight are skipped while bit 25 overrides it.
// R17: Unchanged bit 24 starts nothing; delays counted by a fixed millisecond tick.
// R18: A reversed request turns the sequence round from the current step.
module pps_top
  import pps_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic vdd_request_in,
  input wire logic lcd_request_in,
  output logic panel_vdd_enable,
  output logic panel_data_enable,
  output logic panel_contrast_enable,
  output logic backlight_off_n
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed
  {
    pps_ax_t ax;
    logic aw_got;
    logic w_got;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] reg_v;
    logic [2:0] step;
    logic [16:0] tick_cnt;
    logic [7:0] ms_cnt;
    logic vdd;
    logic data;
    logic con;
    logic bl_n;
  } pps_state_t;

  pps_state_t s_q;
  pps_state_t s_d;

  // Delay length in milliseconds for one phase bit
  function automatic logic [7:0] pps_delay_ms(input logic sel);
    pps_delay_ms = sel ? PPS_LONG_MS_W : PPS_SHORT_MS_W;
  endfunction

  // Merge write data into the register under byte strobes
  function automatic logic [31:0] pps_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        m[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    pps_merge = (m & PPS_WR_MASK) | (old & ~PPS_WR_MASK);
  endfunction

  logic req_on;
  logic ext_mode;
  logic bl_ovr;
  logic ms_tick;
  logic [7:0] phase_ms;
  logic wr_hit;
  logic [31:0] wr_val;

  assign req_on = s_q.reg_v[PPS_PWR_REQ_BIT];
  assign ext_mode = s_q.reg_v[PPS_SRC_SEL_BIT]; // R1
  assign bl_ovr = s_q.reg_v[PPS_BL_OVR_BIT];
  assign ms_tick = (s_q.tick_cnt == 17'(PPS_MS_CYCLES - 1)); // R17

  // Delay before leaving the current step in the current direction
  always_comb
  begin
    phase_ms = PPS_SHORT_MS_W;
    if (req_on)
    begin
      case (s_q.step)
        3'h1: phase_ms = pps_delay_ms(s_q.reg_v[PPS_UP_VDD_DATA_BIT]); // R13
        3'h2: phase_ms = pps_delay_ms(s_q.reg_v[PPS_UP_DATA_CON_BIT]);
        3'h3: phase_ms = pps_delay_ms(s_q.reg_v[PPS_UP_CON_BL_BIT]);
        default: phase_ms = PPS_SHORT_MS_W;
      endcase
    end
    else
    begin
      case (s_q.step)
        3'h3: phase_ms = pps_delay_ms(s_q.reg_v[PPS_DN_BL_CON_BIT]); // R14
        3'h2: phase_ms = pps_delay_ms(s_q.reg_v[PPS_DN_CON_DATA_BIT]);
        3'h1: phase_ms = pps_delay_ms(s_q.reg_v[PPS_DN_DATA_VDD_BIT]);
        default: phase_ms = PPS_SHORT_MS_W;
      endcase
    end
  end

  assign wr_hit = (s_q.awaddr == PPS_PWR_MGMT_OFFSET);
  assign wr_val = pps_merge(s_q.reg_v, s_q.wdata, s_q.wstrb);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic adv;
    logic skip;
    s_d = s_q;
    adv = 1'b0;
    skip = 1'b0;

    // Bus slave: one write and one read at a time, read has priority
    case (s_q.ax)
      PPS_AX_IDLE:
      begin
        s_d.awready = 1'b0;
        s_d.wready = 1'b0;
        s_d.arready = 1'b0;
        if (s_axi_awvalid && s_q.awready)
        begin
          s_d.aw_got = 1'b1;
          s_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_q.wready)
        begin
          s_d.w_got = 1'b1;
          s_d.wdata = s_axi_wdata;
          s_d.wstrb = s_axi_wstrb;
        end
        if (s_axi_arvalid && s_q.arready)
        begin
          s_d.rvalid = 1'b1;
          s_d.rresp = PPS_RESP_SLVERR;
          s_d.rdata = 32'h00000000;
          if (s_axi_araddr == PPS_PWR_MGMT_OFFSET)
          begin
            s_d.rdata = s_q.reg_v; // R8
            s_d.rresp = PPS_RESP_OKAY;
          end
          s_d.ax = PPS_AX_RRESP;
        end
        else if (s_q.aw_got && s_q.w_got)
        begin
          s_d.aw_got = 1'b0;
          s_d.w_got = 1'b0;
          s_d.bvalid = 1'b1;
          s_d.bresp = wr_hit ? PPS_RESP_OKAY : PPS_RESP_SLVERR;
          if (wr_hit)
          begin
            // Request edges only arise from a real change of the bit
            s_d.reg_v = wr_val; // R6 R7 R17
          end
          s_d.ax = PPS_AX_WRESP;
        end
        else
        begin
          s_d.awready = !s_d.aw_got && !(s_axi_awvalid && s_q.awready);
          s_d.wready = !s_d.w_got && !(s_axi_wvalid && s_q.wready);
          s_d.arready = !(s_axi_arvalid && s_q.arready);
        end
      end
      PPS_AX_WRESP:
      begin
        if (s_axi_bready)
        begin
          s_d.bvalid = 1'b0;
          s_d.ax = PPS_AX_IDLE;
        end
      end
      PPS_AX_RRESP:
      begin
        if (s_axi_rready)
        begin
          s_d.rvalid = 1'b0;
          s_d.ax = PPS_AX_IDLE;
        end
      end
      default:
      begin
        s_d.ax = PPS_AX_IDLE;
      end
    endcase

    // Millisecond time base
    s_d.tick_cnt = ms_tick ? 17'h00000 : s_q.tick_cnt + 17'h00001;

    // Sequencer: step chases the request, reversing from where it stands
    if (ext_mode)
    begin
      s_d.ms_cnt = 8'h00; // R2 R11
    end
    else if ((req_on && s_q.step == PPS_STEP_ON) ||
             (!req_on && s_q.step == PPS_STEP_OFF))
    begin
      s_d.ms_cnt = 8'h00;
    end
    else
    begin
      // First move out of the off step or the on step is immediate
      if ((req_on && s_q.step == PPS_STEP_OFF) ||
          (!req_on && s_q.step == PPS_STEP_ON))
      begin
        adv = 1'b1;
      end
      // Backlight-adjacent delays drop out under override
      skip = bl_ovr && ((req_on && s_q.step == 3'h3) ||
                        (!req_on && s_q.step == 3'h3)); // R16
      if (skip)
      begin
        adv = 1'b1;
      end
      if (!adv && ms_tick)
      begin
        if (s_q.ms_cnt + 8'h01 >= phase_ms) // R9
        begin
          adv = 1'b1;
        end
        else
        begin
          s_d.ms_cnt = s_q.ms_cnt + 8'h01;
        end
      end
      if (adv)
      begin
        s_d.ms_cnt = 8'h00;
        s_d.step = req_on ? s_q.step + 3'h1 : s_q.step - 3'h1; // R18
      end
    end

    // Outputs
    if (ext_mode)
    begin
      s_d.vdd = vdd_request_in; // R3
      s_d.con = lcd_request_in; // R3
      s_d.data = vdd_request_in;
      s_d.bl_n = !bl_ovr; // R4
    end
    else
    begin
      s_d.vdd = (s_d.step >= 3'h1); // R5 R13 R14
      s_d.data = (s_d.step >= 3'h2);
      s_d.con = (s_d.step >= 3'h3);
      s_d.bl_n = (s_d.step == PPS_STEP_ON) && !bl_ovr; // R10 R15
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q <= '0; // R12
      s_q.ax <= PPS_AX_IDLE;
    end
    else if (clk_en)
    begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_arready = s_q.arready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign panel_vdd_enable = s_q.vdd;
  assign panel_data_enable = s_q.data;
  assign panel_contrast_enable = s_q.con;
  assign backlight_off_n = s_q.bl_n;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_ext_vdd_follow: assert property ( // R3
    (clk_en && ext_mode) |=> (panel_vdd_enable == $past(vdd_request_in)))
    else $error("vdd enable does not follow request");
  a_ext_con_follow: assert property ( // R3
    (clk_en && ext_mode) |=> (panel_contrast_enable == $past(lcd_request_in)))
    else $error("contrast enable does not follow request");
  a_ext_bl_follow: assert property ( // R4
    (clk_en && ext_mode) |=> (backlight_off_n == !$past(bl_ovr)))
    else $error("backlight not driven from override bit");
  a_bl_override: assert property ( // R10
    (clk_en && bl_ovr) |=> !backlight_off_n)
    else $error("override did not turn backlight off");
  a_up_order: assert property ( // R13
    (!ext_mode && panel_contrast_enable) |-> (panel_data_enable &&
     panel_vdd_enable))
    else $error("contrast on without data and vdd");
  a_down_bl_first: assert property ( // R14
    (!ext_mode && backlight_off_n) |-> panel_contrast_enable)
    else $error("backlight on without contrast");
  a_int_step_out: assert property ( // R5
    (clk_en && !ext_mode) |=> (panel_vdd_enable == (s_q.step != 3'h0)))
    else $error("vdd enable not tied to step");
  a_no_jump: assert property ( // R18
    (clk_en && !ext_mode && !$past(ext_mode)) |->
    (s_q.step - $past(s_q.step) inside {3'h0, 3'h1, 3'h7}))
    else $error("sequencer moved more than one step");
  a_ext_frozen: assert property ( // R2
    (clk_en && ext_mode) |=> (s_q.ms_cnt == 8'h00))
    else $error("delay counter ran in external mode");
  a_reg_reset: assert property ( // R12
    $rose(arst_n) |-> (s_q.reg_v == PPS_PWR_MGMT_RESET))
    else $error("register not reset to zero");

  c_power_up: cover property (s_q.step == 3'h3 ##1 s_q.step == PPS_STEP_ON);
  c_power_down: cover property (s_q.step == 3'h1 ##1 s_q.step == 3'h0);
  c_reverse: cover property (s_q.step == 3'h2 ##1 s_q.step == 3'h3
                             ##[1:1000] s_q.step == 3'h2);
  c_ext_mode: cover property (ext_mode && panel_vdd_enable);
endmodule

/* File: sim/pps_panel_model.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Panel rails and backlight
// ----------------------------------------------------------------
module pps_panel_model
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic check_en,
  input wire logic vdd_en,
  input wire logic data_en,
  input wire logic con_en,
  input wire logic bl_off_n,
  output logic order_err
);
  // A stage coming up above an unpowered one would stress the glass.
  // External mode lets the pins run free, so the bench gates the check.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      order_err <= 1'b0;
    else if (check_en && ((data_en && !vdd_en) || (con_en && !data_en)
             || (bl_off_n && !con_en)))
      order_err <= 1'b1;
  end
endmodule

/* File: sim/panel_power_sequencer_test.sv */
`timescale 1ns/1ns
module panel_power_sequencer_test
  import pps_pkg::*;
;
  logic mclk, arst_n, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, vdd_request_in;
  logic lcd_request_in, panel_vdd_enable, panel_data_enable;
  logic panel_contrast_enable, backlight_off_n, check_en, order_err;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  int fails, samples_checked;

  pps_top DUT (.mclk, .arst_n, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .vdd_request_in,
    .lcd_request_in, .panel_vdd_enable, .panel_data_enable,
    .panel_contrast_enable, .backlight_off_n);

  pps_panel_model panel (.mclk, .arst_n, .check_en,
    .vdd_en(panel_vdd_enable), .data_en(panel_data_enable),
    .con_en(panel_contrast_enable), .bl_off_n(backlight_off_n),
    .order_err);

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic check(input string nm, input logic [33:0] seen,
                       input logic [33:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results;
    if (bq.size() + rq.size() != 0)
      fails++;
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask

  task automatic pins(input logic [3:0] e);
    check("pins", {30'h0, panel_vdd_enable, panel_data_enable,
          panel_contrast_enable, backlight_off_n}, {30'h0, e});
  endtask

  // ----------------------------------------------------------------
  // Bus master: only the watchdog ends a wait; an edge passes after each
  // response so a following call never re-raises a ready in the same step
  // ----------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    rq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
    @(posedge mclk);
  endtask

  always @(posedge mclk)
  begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready)
      check("bresp", {32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
    if (s_axi_rvalid === 1'b1 && s_axi_rready)
      check("rdata", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    {clk_en, s_axi_wstrb, check_en} = 6'h3F;
    {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, vdd_request_in, lcd_request_in} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    v = $urandom(32'h4C1E7610);
    cyc(8);
    arst_n <= 1'b1;
    cyc(2);
    pins(4'h0);
    rd(PPS_PWR_MGMT_OFFSET, {PPS_RESP_OKAY, PPS_PWR_MGMT_RESET});
    wr(12'h40C, 32'hFFFFFFFF, PPS_RESP_SLVERR);
    rd(12'h40C, {PPS_RESP_SLVERR, 32'h0});
    v = $urandom() & 32'h00FC0000;
    wr(PPS_PWR_MGMT_OFFSET, v, PPS_RESP_OKAY);
    rd(PPS_PWR_MGMT_OFFSET, {PPS_RESP_OKAY, v});
    cyc(20);
    pins(4'h0);
    // Pins pass through; stored power bit and delays must be ignored
    check_en <= 1'b0;
    wr(PPS_PWR_MGMT_OFFSET, v | 32'h0B000000, PPS_RESP_OKAY);
    repeat (8)
    begin
      vdd_request_in <= 1'($urandom());
      lcd_request_in <= 1'($urandom());
      cyc(3);
      pins({vdd_request_in, vdd_request_in, lcd_request_in, 1'b0});
    end
    // Clock enable low must freeze the pass-through outputs
    clk_en <= 1'b0;
    vdd_request_in <= ~vdd_request_in;
    cyc(3);
    pins({~vdd_request_in, ~vdd_request_in, lcd_request_in, 1'b0});
    clk_en <= 1'b1;
    cyc(2);
    pins({vdd_request_in, vdd_request_in, lcd_request_in, 1'b0});
    vdd_request_in <= 1'b0;
    lcd_request_in <= 1'b0;
    wr(PPS_PWR_MGMT_OFFSET, v, PPS_RESP_OKAY);
    cyc(3);
    pins(4'h0);
    check_en <= 1'b1;
    wr(PPS_PWR_MGMT_OFFSET, v | 32'h01000000, PPS_RESP_OKAY);
    cyc(4);
    pins(4'h8);
    rd(PPS_PWR_MGMT_OFFSET, {PPS_RESP_OKAY, v | 32'h01000000});
    wr(PPS_PWR_MGMT_OFFSET, v | 32'h01000000, PPS_RESP_OKAY);
    cyc(100);
    pins(4'h8);
    // Reversal from the vdd step keeps vdd on for at least the next 100 cycles
    wr(PPS_PWR_MGMT_OFFSET, v, PPS_RESP_OKAY);
    cyc(100);
    pins(4'h8);
    rd(PPS_PWR_MGMT_OFFSET, {PPS_RESP_OKAY, v});
    check("order", {33'h0, order_err}, 34'h0);
    arst_n <= 1'b0;
    cyc(2);
    pins(4'h0);
    arst_n <= 1'b1;
    cyc(2);
    rd(PPS_PWR_MGMT_OFFSET, {PPS_RESP_OKAY, PPS_PWR_MGMT_RESET});
    results();
  end

  initial
  begin
    #100000;
    fails++;
    results();
  end
endmodule
